// ---- sim/smb_ctrl_properties.sv ----
// port-level assertions for the smbus controller
// assumes it is bound onto smb_ctrl and the map in smb_cfg.svh
`timescale 1ns/1ps
`default_nettype none
`include "smb_cfg.svh"
module smb_ctrl_properties #(
  parameter int HALF_CYC = `SCL_HALF_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire smb_pkg::byte_t SFR_ADDR_IN,
  input wire smb_pkg::byte_t SFR_WDATA_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire smb_pkg::byte_t SFR_RDATA_OUT,
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_OUT,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT
);
  import smb_pkg::*;
  // start takes three scl ticks, so allow a few ticks per step
  localparam int GO_MAX = 4 * HALF_CYC + 20;
  byte_t mask_q;
  byte_t addr_q;
  wire logic wr_mask = SFR_WR_IN && SFR_ADDR_IN == `MASK_ADR;
  wire logic wr_addr = SFR_WR_IN && SFR_ADDR_IN == `ADDR_ADR;
  wire logic unmapped = !(SFR_ADDR_IN inside
    {`CTRL_ADR, `DATA_ADR, `MASK_ADR, `ADDR_ADR});
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      mask_q <= `MASK_RST;
      addr_q <= `ADDR_RST;
    end else begin
      if (wr_mask) mask_q <= SFR_WDATA_IN;
      if (wr_addr) addr_q <= SFR_WDATA_IN;
    end
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_rd(a);
    SFR_RD_IN && SFR_ADDR_IN == a;
  endsequence
  sequence s_clr;
    SFR_WR_IN && SFR_ADDR_IN == `CTRL_ADR && !SFR_WDATA_IN[0];
  endsequence
  sequence s_go;
    SFR_WR_IN && SFR_ADDR_IN == `CTRL_ADR && SFR_WDATA_IN[5];
  endsequence
  chk_rst_quiet: assert property ($rose(RST_B_IN) |->
    SFR_RDATA_OUT == 8'h00 && !SCL_OE_OUT && !SDA_OE_OUT)
    else $error("outputs not quiet after reset");
  chk_rd_hold: assert property (!SFR_RD_IN |=> $stable(SFR_RDATA_OUT))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (SFR_RD_IN && unmapped |=>
    SFR_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  chk_mask_rw: assert property (
    s_rd(`MASK_ADR) |=> SFR_RDATA_OUT == mask_q)
    else $error("mask register read wrong");
  chk_addr_rw: assert property (
    s_rd(`ADDR_ADR) |=> SFR_RDATA_OUT == addr_q)
    else $error("address register read wrong");
  chk_open_drain: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin data not held low");
  chk_arb_clear: assert property (
    s_clr ##2 s_rd(`CTRL_ADR) |=> !SFR_RDATA_OUT[2])
    else $error("arbitration loss kept after clear");
  chk_start_drive: assert property (
    s_go |-> ##[1:GO_MAX] SDA_OE_OUT ##[1:GO_MAX] SCL_OE_OUT)
    else $error("start not driven");
  chk_event_hold: assert property (
    s_rd(`CTRL_ADR) ##1 (SFR_RDATA_OUT[0] &&
    (SFR_RDATA_OUT[7] || SFR_RDATA_OUT[5])) |-> ##[0:1] SCL_OE_OUT)
    else $error("scl not held while event pending");
endmodule
bind smb_ctrl smb_ctrl_properties #(.HALF_CYC(HALF_CYC)) u_props (
  .CLOCK_IN, .RST_B_IN, .SFR_ADDR_IN, .SFR_WDATA_IN, .SFR_WR_IN,
  .SFR_RD_IN, .SFR_RDATA_OUT, .SCL_IN, .SCL_OUT, .SCL_OE_OUT,
  .SDA_IN, .SDA_OUT, .SDA_OE_OUT);
`default_nettype wire

// ---- sim/smb_peer.sv ----
// foreign smbus master and slave facing the controller
// assumes wired-and lines with pull-ups built by the bench
`timescale 1ns/1ps
`default_nettype none
module smb_peer (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_pull_out,
  output logic sda_pull_out
);
  int miss = 0;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  // a peer that wins arbitration keeps sda low
  task automatic hold_sda(input logic v);
    sda_pull_out = v;
  endtask
  // stretching honoured, but never waited on forever
  task automatic wait_scl(input logic v);
    int n;
    n = 0;
    while (scl_in !== v && n < 4000) begin
      #50;
      n++;
    end
    if (n == 4000) miss++;
  endtask
  task automatic start();
    sda_pull_out = 1'b1;
    #400;
    scl_pull_out = 1'b1;
    #200;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull_out = !b;
    #200;
    scl_pull_out = 1'b0;
    wait_scl(1'b1);
    #400;
    r = sda_in;
    scl_pull_out = 1'b1;
    #200;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    #200;
    scl_pull_out = 1'b0;
    wait_scl(1'b1);
    #400;
    sda_pull_out = 1'b0;
    #400;
  endtask
  // sda moves a clock after scl falls, so no false stop is seen
  task automatic take(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wait_scl(1'b1);
      d = {d[6:0], sda_in};
      wait_scl(1'b0);
    end
    #100;
    sda_pull_out = 1'b1;
    wait_scl(1'b1);
    wait_scl(1'b0);
    #100;
    sda_pull_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench: register driver, read scoreboard, bus peer
// assumes smb_ctrl, smb_peer and the bound property checker
`timescale 1ns/1ps
`default_nettype none
`include "smb_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, g, e); end end
`define WAIT(c) for (wt = 0; wt < 3000 && !(c); wt++) @(negedge clk); \
  if (wt == 3000) begin error_cnt++; finish_test(); end
module testbench;
  import smb_pkg::*;
  localparam int HP = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic scl_oe, sda_oe, sda_o, p_scl, p_sda, ack;
  byte_t addr = 8'h00;
  byte_t wdata = 8'h00;
  byte_t rdata, got, md, ab, e_v, m_v;
  bit [31:0] t;
  int error_cnt = 0;
  int comparisons = 0;
  int wt, i;
  int seed = 92;
  byte_t exp_q[$];
  byte_t msk_q[$];
  // own addr, mask, address byte, expected ack
  bit [31:0] tbl [7] = '{32'h68ff6801, 32'h68ff6a00, 32'h68fd6801,
    32'h68ff0000, 32'h69ff0001, 32'he0e7f801, 32'he0e7e200};
  wire logic scl_w = !(scl_oe | p_scl);
  wire logic sda_w = !(sda_oe | p_sda);
  always #50 clk = ~clk;
  smb_ctrl #(.HALF_CYC(HP)) u_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_RDATA_OUT(rdata), .SCL_IN(scl_w), .SCL_OUT(),
    .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe));
  smb_peer u_peer (.scl_in(scl_w), .sda_in(sda_w),
    .scl_pull_out(p_scl), .sda_pull_out(p_sda));
  task automatic sfr_wr(input byte_t a, input byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic sfr_rd(input byte_t a, input byte_t e, input byte_t m);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic poll_event();
    wt = 0;
    do begin
      sfr_rd(`CTRL_ADR, 8'h00, 8'h00);
      wt++;
    end while (rdata[0] !== 1'b1 && wt < 400);
    if (wt == 400) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    error_cnt += u_peer.miss;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data lands one edge after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      `CHK(rdata & m_v, e_v)
    end
    rd_q <= rd;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    sfr_rd(`CTRL_ADR, 8'h00, 8'hff);
    sfr_rd(`MASK_ADR, `MASK_RST, 8'hff);
    sfr_rd(`ADDR_ADR, 8'h00, 8'hff);
    sfr_rd(8'h55, 8'h00, 8'hff);
    sfr_wr(`CTRL_ADR, 8'hcc);
    sfr_rd(`CTRL_ADR, 8'h00, 8'hff);
    sfr_wr(`CTRL_ADR, 8'h01);
    sfr_rd(`CTRL_ADR, 8'h01, 8'hff);
    sfr_wr(`CTRL_ADR, 8'h00);
    sfr_rd(`CTRL_ADR, 8'h00, 8'hff);
    md = byte_t'($random(seed));
    sfr_wr(`DATA_ADR, md);
    sfr_wr(`CTRL_ADR, 8'h20);
    poll_event();
    // begin flag written by software stays set until software clears it
    sfr_rd(`CTRL_ADR, 8'he1, 8'hff);
    fork
      u_peer.take(got);
      sfr_wr(`CTRL_ADR, 8'h00);
    join
    `CHK(got, md)
    poll_event();
    sfr_rd(`CTRL_ADR, 8'h83, 8'h83);
    sfr_wr(`CTRL_ADR, 8'h10);
    `WAIT(sda_oe === 1'b1)
    `WAIT(scl_w === 1'b1 && sda_w === 1'b1)
    repeat (HP + 3) @(negedge clk);
    sfr_rd(`CTRL_ADR, 8'h00, 8'h90);
    for (i = 0; i < 7; i++) begin
      t = tbl[i];
      sfr_wr(`ADDR_ADR, t[31:24]);
      sfr_wr(`MASK_ADR, t[23:16]);
      // random values only in the don't-care address bits
      ab = t[15:8] | (byte_t'($random(seed)) & ~t[23:16] & 8'hfe);
      repeat (4) @(negedge clk);
      u_peer.start();
      u_peer.send(ab, ack);
      `CHK(ack, t[0])
      if (t[0]) begin
        poll_event();
        sfr_rd(`CTRL_ADR, 8'h21, 8'h21);
        sfr_wr(`CTRL_ADR, 8'h00);
      end
      u_peer.stop();
      if (t[0]) begin
        poll_event();
        sfr_rd(`CTRL_ADR, 8'h11, 8'h11);
        sfr_wr(`CTRL_ADR, 8'h00);
      end
    end
    // manual acknowledge: firmware answers the address byte
    sfr_wr(`MASK_ADR, 8'hfe);
    repeat (4) @(negedge clk);
    u_peer.start();
    fork
      u_peer.send(8'h68, ack);
      begin
        poll_event();
        sfr_rd(`CTRL_ADR, 8'h29, 8'h29);
        sfr_wr(`CTRL_ADR, 8'h02);
      end
    join
    `CHK(ack, 1'b1)
    repeat (3) @(negedge clk);
    sfr_rd(`CTRL_ADR, 8'h00, 8'h09);
    u_peer.stop();
    poll_event();
    sfr_rd(`CTRL_ADR, 8'h11, 8'h11);
    sfr_wr(`CTRL_ADR, 8'h00);
    // peer holds sda low while the block sends a one
    sfr_wr(`DATA_ADR, 8'hff);
    sfr_wr(`CTRL_ADR, 8'h20);
    poll_event();
    u_peer.hold_sda(1'b1);
    sfr_wr(`CTRL_ADR, 8'h00);
    poll_event();
    sfr_rd(`CTRL_ADR, 8'h05, 8'hfd);
    u_peer.hold_sda(1'b0);
    sfr_wr(`CTRL_ADR, 8'h00);
    sfr_rd(`CTRL_ADR, 8'h00, 8'h05);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- src/addr_match.sv ----
// masked own-address and general call compare
// assumes a stable address byte from the caller's shifter
`timescale 1ns/1ps
`default_nettype none
`include "smb_cfg.svh"

module addr_match (
  input wire logic [6:0] addr_in,
  input wire logic [6:0] own_in,
  input wire logic [6:0] mask_in,
  input wire logic bcast_en_in,
  output var logic hit_out
);
  wire logic [6:0] diff = (addr_in ^ own_in) & mask_in;
  wire logic bcast = bcast_en_in && (addr_in == `BCAST_ADDR);

  assign hit_out = (diff == 7'h00) || bcast;

endmodule
`default_nettype wire

// ---- src/bus_sense.sv ----
// pin synchroniser and start, stop and scl edge detection
// assumes scl and sda pins are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "smb_cfg.svh"

module bus_sense (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output var smb_pkg::bus_cond_t cond_out
);
  import smb_pkg::*;

  // stage 0 feeds stage 1 only; stage 2 is the history for edges
  logic [2:0] scl_q;
  logic [2:0] sda_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      scl_q <= `LINE_IDLE;
      sda_q <= `LINE_IDLE;
    end else begin
      scl_q <= {scl_q[1:0], scl_pin_in};
      sda_q <= {sda_q[1:0], sda_pin_in};
    end
  end

  wire logic scl_hi = scl_q[1] && scl_q[2];
  wire logic sda_fell = sda_q[2] && !sda_q[1];
  wire logic sda_rose = !sda_q[2] && sda_q[1];

  assign cond_out.scl = scl_q[1];
  assign cond_out.sda = sda_q[1];
  assign cond_out.scl_rise = scl_q[1] && !scl_q[2];
  assign cond_out.scl_fall = !scl_q[1] && scl_q[2];
  assign cond_out.start_seen = scl_hi && sda_fell;
  assign cond_out.stop_seen = scl_hi && sda_rose;

endmodule
`default_nettype wire

// ---- src/smb_cfg.svh ----
// register map, reset values and timing of the smbus block
// assumes a 10 mhz system clock and inclusion by name only
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH

`define CTRL_ADR 8'hc0
`define DATA_ADR 8'hc2
`define MASK_ADR 8'hce
`define ADDR_ADR 8'hcf

`define CTRL_RST 8'h00
`define DATA_RST 8'h00
`define ADDR_RST 8'h00
`define MASK_RST 8'hfe
`define LINE_IDLE 3'h7

`define AUTO_ACK_POS 0
`define BCAST_POS 0
`define BCAST_ADDR 7'h00
`define BYTE_BITS 4'h8

`define CLK_NS 100
`define SCL_HALF_NS 5000
`define SCL_HALF_CYC ((`SCL_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- src/smb_ctrl.sv ----
// smbus flag engine, auto acknowledge and, in auto mode, address recognition
// assumes an sfr port on CLOCK_IN and open-drain scl/sda pads
`timescale 1ns/1ps
`default_nettype none
`include "smb_cfg.svh"

module smb_ctrl #(
  parameter int HALF_CYC = `SCL_HALF_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire smb_pkg::byte_t SFR_ADDR_IN,
  input wire smb_pkg::byte_t SFR_WDATA_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  output var smb_pkg::byte_t SFR_RDATA_OUT,
  input wire logic SCL_IN,
  output var logic SCL_OUT,
  output var logic SCL_OE_OUT,
  input wire logic SDA_IN,
  output var logic SDA_OUT,
  output var logic SDA_OE_OUT
);
  import smb_pkg::*;

  localparam int DW = 16;

  bus_cond_t bc;
  ctrl_t ctl_q;
  ctrl_t c;
  byte_t adr_q;
  byte_t adm_q;
  byte_t sh_q;
  byte_t sh_d;
  byte_t rd_val;
  phase_t ph_q;
  phase_t ph_d;
  step_t sub_q;
  step_t sub_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [DW-1:0] div_q;
  logic scl_oe_q;
  logic scl_oe_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic adrd_q;
  logic adrd_d;
  logic first_q;
  logic first_d;
  logic gen_q;
  logic gen_d;
  logic req_q;
  logic req_d;
  logic wrote_q;
  logic wrote_d;
  logic busy_q;
  logic lose;
  logic hit;

  bus_sense u_sense (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .scl_pin_in(SCL_IN),
    .sda_pin_in(SDA_IN),
    .cond_out(bc)
  );

  wire logic [6:0] own_addr = adr_q[7:1];
  wire logic [6:0] cmp_mask = adm_q[7:1];
  wire logic bcast_en = adr_q[`BCAST_POS];
  wire logic auto_ack = adm_q[`AUTO_ACK_POS];

  addr_match u_match (
    .addr_in(sh_q[7:1]),
    .own_in(own_addr),
    .mask_in(cmp_mask),
    .bcast_en_in(bcast_en),
    .hit_out(hit)
  );

  wire logic tick = (div_q == DW'(HALF_CYC - 1));
  wire logic wr_ctl = SFR_WR_IN && (SFR_ADDR_IN == `CTRL_ADR);
  wire logic wr_dat = SFR_WR_IN && (SFR_ADDR_IN == `DATA_ADR);
  wire logic wr_adm = SFR_WR_IN && (SFR_ADDR_IN == `MASK_ADR);
  wire logic wr_adr = SFR_WR_IN && (SFR_ADDR_IN == `ADDR_ADR);
  wire ctrl_t wr_c = ctrl_t'(SFR_WDATA_IN);
  wire logic tx_now = ctl_q.transmit_direction_flag;
  // first byte, seven bits, as slave
  wire logic slv_adr = first_q && !ctl_q.bus_owner_flag;
  wire logic gen_scl = (ph_q == PH_DATA) || (ph_q == PH_ACK);

  assign rd_val = (SFR_ADDR_IN == `CTRL_ADR) ? byte_t'(ctl_q) :
                  (SFR_ADDR_IN == `DATA_ADR) ? sh_q :
                  (SFR_ADDR_IN == `MASK_ADR) ? adm_q :
                  (SFR_ADDR_IN == `ADDR_ADR) ? adr_q : 8'h00;

  always_comb begin
    c = ctl_q;
    ph_d = ph_q;
    sub_d = sub_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    adrd_d = adrd_q;
    first_d = first_q;
    gen_d = gen_q;
    req_d = req_q;
    wrote_d = wrote_q;
    lose = 1'b0;
    if (wr_ctl) begin
      c.begin_condition_flag = wr_c.begin_condition_flag;
      c.end_condition_flag = wr_c.end_condition_flag;
      c.ack_status_bit = wr_c.ack_status_bit;
      c.event_flag = wr_c.event_flag;
      if (!wr_c.event_flag) begin
        c.arbitration_loss_flag = 1'b0;
      end
      req_d = wr_c.begin_condition_flag;
    end
    if (wr_dat) begin
      sh_d = SFR_WDATA_IN;
      wrote_d = 1'b1;
    end
    // master clock waits for scl high, so slaves may stretch
    if (c.bus_owner_flag && !ctl_q.event_flag && tick && gen_scl) begin
      scl_oe_d = !scl_oe_q && bc.scl;
    end
    unique case (ph_q)
      PH_IDLE: begin
        if (req_q && !busy_q && !c.event_flag) begin
          ph_d = PH_START;
          sub_d = S0;
        end
      end
      PH_START: begin
        if (sub_q == S0) begin
          sda_oe_d = 1'b0;
          scl_oe_d = 1'b0;
          if (tick) begin
            sub_d = S1;
          end
        end else if (sub_q == S1) begin
          if (tick && bc.scl && bc.sda) begin
            sda_oe_d = 1'b1;
            gen_d = 1'b1;
            sub_d = S2;
          end else if (tick && c.bus_owner_flag) begin
            lose = 1'b1;
          end
        end else if (tick) begin
          scl_oe_d = 1'b1;
          gen_d = 1'b0;
          req_d = 1'b0;
          first_d = 1'b0;
          c.bus_owner_flag = 1'b1;
          c.transmit_direction_flag = 1'b1;
          c.event_flag = 1'b1;
          ph_d = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (!c.event_flag) begin
          if (c.bus_owner_flag && req_d) begin
            ph_d = PH_START;
            sub_d = S0;
          end else if (c.bus_owner_flag && c.end_condition_flag) begin
            ph_d = PH_STOP;
            sub_d = S0;
          end else if (c.bus_owner_flag || adrd_q) begin
            c.transmit_direction_flag = wrote_q;
            wrote_d = 1'b0;
            cnt_d = 4'h0;
            sda_oe_d = wrote_q && !sh_d[7];
            ph_d = PH_DATA;
          end else begin
            ph_d = PH_IDLE;
          end
        end
      end
      PH_DATA: begin
        if (bc.scl_rise) begin
          sh_d = {sh_q[6:0], bc.sda};
          cnt_d = cnt_q + 4'h1;
          if (tx_now && !sda_oe_q && !bc.sda && c.bus_owner_flag) begin
            lose = 1'b1;
          end
        end else if (bc.scl_fall && cnt_q == `BYTE_BITS) begin
          ph_d = PH_ACK;
          sub_d = S0;
          first_d = 1'b0;
          sda_oe_d = 1'b0;
          if (!tx_now && auto_ack) begin
            if (!slv_adr) begin
              sda_oe_d = c.ack_status_bit;
            end else if (hit) begin
              sda_oe_d = 1'b1;
              adrd_d = 1'b1;
              c.begin_condition_flag = 1'b1;
            end else begin
              ph_d = PH_IDLE;
            end
          end else if (!tx_now) begin
            c.ack_request_flag = 1'b1;
            c.event_flag = 1'b1;
            sub_d = S1;
            if (slv_adr) begin
              adrd_d = 1'b1;
              c.begin_condition_flag = 1'b1;
            end
          end
        end else if (bc.scl_fall) begin
          sda_oe_d = tx_now && !sh_q[7];
        end
      end
      PH_ACK: begin
        if (sub_q == S1) begin
          if (!c.event_flag) begin
            sda_oe_d = c.ack_status_bit;
            sub_d = S2;
          end
        end else if (bc.scl_rise) begin
          if (tx_now) begin
            c.ack_status_bit = !bc.sda;
          end
        end else if (bc.scl_fall) begin
          sda_oe_d = 1'b0;
          c.ack_request_flag = 1'b0;
          if (sub_q == S2) begin
            cnt_d = 4'h0;
            ph_d = PH_DATA;
          end else begin
            c.event_flag = 1'b1;
            ph_d = PH_WAIT;
          end
        end
      end
      PH_STOP: begin
        if (sub_q == S0) begin
          sda_oe_d = 1'b1;
          scl_oe_d = 1'b1;
          if (tick) begin
            scl_oe_d = 1'b0;
            sub_d = S1;
          end
        end else if (sub_q == S1) begin
          if (tick && !bc.scl) begin
            lose = 1'b1;
          end else if (tick) begin
            sda_oe_d = 1'b0;
            sub_d = S2;
          end
        end else if (tick) begin
          c.bus_owner_flag = 1'b0;
          c.end_condition_flag = 1'b0;
          ph_d = PH_IDLE;
        end
      end
      default: begin
        ph_d = PH_IDLE;
      end
    endcase
    // own start is masked by gen_q so it is not seen as foreign
    if (bc.start_seen && !gen_q) begin
      if (c.bus_owner_flag && !ctl_q.begin_condition_flag) begin
        lose = 1'b1;
      end else begin
        c.transmit_direction_flag = 1'b0;
        if (!c.bus_owner_flag) begin
          ph_d = PH_DATA;
          cnt_d = 4'h0;
          first_d = 1'b1;
          adrd_d = 1'b0;
          sda_oe_d = 1'b0;
        end
      end
    end
    if (bc.stop_seen) begin
      if (adrd_q) begin
        c.end_condition_flag = 1'b1;
        c.event_flag = 1'b1;
      end
      adrd_d = 1'b0;
      if (!c.bus_owner_flag) begin
        ph_d = PH_IDLE;
      end
    end
    if (lose) begin
      c.arbitration_loss_flag = 1'b1;
      c.event_flag = 1'b1;
      c.bus_owner_flag = 1'b0;
      c.transmit_direction_flag = 1'b0;
      ph_d = PH_IDLE;
      sda_oe_d = 1'b0;
      gen_d = 1'b0;
      req_d = 1'b0;
    end
    if (!c.bus_owner_flag && ph_d != PH_START) begin
      scl_oe_d = 1'b0;
    end
    if (c.event_flag && (c.bus_owner_flag || adrd_d)) begin
      scl_oe_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      adr_q <= `ADDR_RST;
      adm_q <= `MASK_RST;
      SFR_RDATA_OUT <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      if (wr_adr) begin
        adr_q <= SFR_WDATA_IN;
      end
      if (wr_adm) begin
        adm_q <= SFR_WDATA_IN;
      end
      if (SFR_RD_IN) begin
        SFR_RDATA_OUT <= rd_val;
      end
      busy_q <= bc.start_seen || (busy_q && !bc.stop_seen);
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      ctl_q <= ctrl_t'(`CTRL_RST);
      ph_q <= PH_IDLE;
      sub_q <= S0;
      cnt_q <= 4'h0;
      sh_q <= `DATA_RST;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      adrd_q <= 1'b0;
      first_q <= 1'b0;
      gen_q <= 1'b0;
      req_q <= 1'b0;
      wrote_q <= 1'b0;
    end else begin
      ctl_q <= c;
      ph_q <= ph_d;
      sub_q <= sub_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      adrd_q <= adrd_d;
      first_q <= first_d;
      gen_q <= gen_d;
      req_q <= req_d;
      wrote_q <= wrote_d;
    end
  end

  // pads are open drain: data lines only ever pull low
  always_ff @(posedge CLOCK_IN) begin
    SCL_OUT <= 1'b0;
    SDA_OUT <= 1'b0;
  end

  assign SCL_OE_OUT = scl_oe_q;
  assign SDA_OE_OUT = sda_oe_q;

endmodule
`default_nettype wire

// ---- src/smb_pkg.sv ----
// types shared by the smbus controller files
// assumes nothing beyond a systemverilog compiler
package smb_pkg;

  typedef logic [7:0] byte_t;

  // bit order matches the control register, bit 7 first
  typedef struct packed {
    logic bus_owner_flag;
    logic transmit_direction_flag;
    logic begin_condition_flag;
    logic end_condition_flag;
    logic ack_request_flag;
    logic arbitration_loss_flag;
    logic ack_status_bit;
    logic event_flag;
  } ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
  } bus_cond_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_START = 3'b001,
    PH_DATA = 3'b010,
    PH_ACK = 3'b011,
    PH_STOP = 3'b100,
    PH_WAIT = 3'b101
  } phase_t;

  typedef enum logic [1:0] {
    S0 = 2'b00,
    S1 = 2'b01,
    S2 = 2'b10
  } step_t;

endpackage
